// ===== logic/ext_regs_defs.svh
// Offsets, field positions, reset values and widths of the extended register group
`ifndef EXT_REGS_DEFS_SVH
`define EXT_REGS_DEFS_SVH

// ==========================================================
// Register offsets on the management access port
`define ADDR_W 5
`define OFF_CAP_ID 5'h12
`define OFF_ENTROPY 5'h13
`define OFF_EVT_ENABLE 5'h1C
`define OFF_EVT_PENDING 5'h1D
`define OFF_RING 5'h1E

// ==========================================================
// Widths and reset values
`define REG_W 16
`define EVT_W 11
`define ENABLE_RST 16'h0000
`define PENDING_RST 11'h000
`define RD_DATA_RST 16'h0000
`define ENT_SEED_DEF 16'hACE1
`define ENT_TAPS 16'hB400

// ==========================================================
// Capability word fields
`define CAP_BIT_INDUSTRIAL 15
`define CAP_BIT_QUAD 14
`define CAP_BIT_PTP 13
`define CAP_BIT_SEC 12
`define CAP_BIT_DUAL_MEDIA 10
`define CAP_BIT_HI_PREC 9
`define CAP_BIT_KEY256 8
`define CAP_SUFFIX_HI 7
`define CAP_SUFFIX_LO 0

// ==========================================================
// Event bit positions (shared by enable and pending)
`define EVT_BIT_MEM_RING 10
`define EVT_BIT_SEC_EGRESS 9
`define EVT_BIT_SEC_INGRESS 8
`define EVT_BIT_FC_BUFFER 7
`define EVT_BIT_LINE_MAC 6
`define EVT_BIT_HOST_MAC 5
`define EVT_BIT_SWITCHOVER 4
`define EVT_BIT_EEE_LINK_FAIL 3
`define EVT_BIT_RX_QUIET 2
`define EVT_BIT_RX_SLEEP 1
`define EVT_BIT_WAKE_ERR 0

// ==========================================================
// Ring control word fields
`define RING_BIT_STARTUP 15
`define RING_BIT_ADVERTISE 14
`define RING_BIT_LP_ADV 13
`define RING_BIT_FORCE 12
`define RING_ROLE_HI 5
`define RING_ROLE_LO 4
`define RING_BIT_START 0

`endif

// ===== logic/ext_regs_pkg.sv
// Types shared by the extended register group
package ext_regs_pkg;

  // ==========================================================
  // Timing role encoding of the ring status field
  typedef enum logic [1:0] {
    ROLE_SLAVE = 2'b00,
    ROLE_MASTER_TO_SLAVE = 2'b01,
    ROLE_SLAVE_TO_MASTER = 2'b10,
    ROLE_MASTER = 2'b11
  } timing_role_e;

  // ==========================================================
  // Complete state of the register bank
  typedef struct packed {
    logic [15:0] enable;
    logic [10:0] pending;
    logic startup_en;
    logic advertise;
    logic force_en;
    logic lp_adv;
    logic start;
    logic link_seen;
    timing_role_e role;
    logic [15:0] rd_data;
    logic rd_valid;
  } regs_state_s;

  // Complete state of the entropy source
  typedef struct packed {
    logic [15:0] value;
  } entropy_state_s;

endpackage : ext_regs_pkg

// ===== logic/entropy_source.sv
// Free-running 16-bit random word source for the entropy register
`timescale 1ns/1ps
`include "ext_regs_defs.svh"

module entropy_source #(
  parameter logic [15:0] SEED = `ENT_SEED_DEF
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  output logic [15:0] value_out
);

  // An all-zero seed would lock the shift register
  if (SEED == 16'h0000) begin : g_bad_seed
    $error("entropy_source: SEED must be nonzero");
  end

  ext_regs_pkg::entropy_state_s st_q;
  ext_regs_pkg::entropy_state_s st_d;

  // ==========================================================
  // Next state
  always_comb begin
    st_d = st_q;
    st_d.value = {st_q.value[14:0], ^(st_q.value & `ENT_TAPS)};
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_q.value <= SEED;
    end else begin
      st_q <= st_d;
    end
  end

  assign value_out = st_q.value;

  // ==========================================================
  // Checks
  property p_entropy_moves;
    @(posedge clk_in) disable iff (!resetn_in)
      resetn_in ##1 resetn_in |-> (value_out != $past(value_out)) && (value_out != 16'h0000);
  endproperty
  a_entropy_moves: assert property (p_entropy_moves)
    else $error("entropy word stalled or reached zero");

endmodule : entropy_source

// ===== logic/ext_id_irq_ring_regs.sv
// Extended capability, entropy, event and ring switchover registers of one port
// Functional notes
// - Capability bit 15 reads 1 for industrial range, 0 for commercial; read-only.
// - Bits 14, 13, 12, 10 report quad, timing protocol, security, dual media.
// - Bit 9 reads 1 for high-precision timestamping, 0 for low-precision only.
// - Bit 8 reads 1 for 256-bit security keys, 0 for 128-bit only.
// - Entropy register returns a fresh 16-bit random value on each read.
// - Enable bits are sticky read/write, reset 0, 1 lets the event interrupt.
// - Pending bits read 1 while an event waits and clear once read.
// - Event bits 10 down to 5: ring, egress, ingress, buffer, line, host.
// - Event bits 3 down to 0: link fail, quiet timer, sleep timer, wake error.
// - Pending bit 4 sets on switchover completion; enable bit 4 gates it.
// - Ring bits 15, 14, 12 are sticky read/write controls resetting to 0.
// - Ring bit 13 shows the partner's ring advertisement; resets to 0.
// - Ring role field: 00 slave, 10 to master, 11 master, 01 to slave.
// - Stable role first follows the negotiated master/slave outcome at link-up.
// - Writing 1 to ring bit 0 starts a switchover only from a stable role with link up; the bit self-clears.
`timescale 1ns/1ps
`include "ext_regs_defs.svh"

module ext_id_irq_ring_regs #(
  parameter bit CAP_INDUSTRIAL = 1'b0,
  parameter bit CAP_QUAD = 1'b1,
  parameter bit CAP_PTP = 1'b1,
  parameter bit CAP_SEC = 1'b1,
  parameter bit CAP_DUAL_MEDIA = 1'b1,
  parameter bit CAP_HI_PREC = 1'b0,
  parameter bit CAP_KEY256 = 1'b1,
  // Arbitrary neutral suffix value
  parameter logic [7:0] VARIANT_BCD = 8'h01,
  parameter logic [15:0] ENTROPY_SEED = `ENT_SEED_DEF
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [4:0] acc_addr_in,
  input wire logic acc_wr_in,
  input wire logic [15:0] acc_wdata_in,
  input wire logic acc_rd_in,
  output logic [15:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic [10:0] event_in,
  input wire logic link_up_in,
  input wire logic neg_master_in,
  input wire logic lp_ring_adv_in,
  input wire logic switchover_done_in,
  output logic start_switchover_out,
  output logic ring_startup_en_out,
  output logic ring_advertise_out,
  output logic ring_force_out,
  output logic [1:0] timing_role_out,
  output logic irq_out
);

  // ==========================================================
  // Elaboration checks
  if (VARIANT_BCD[7:4] > 4'h9 || VARIANT_BCD[3:0] > 4'h9) begin : g_bad_bcd
    $error("ext_id_irq_ring_regs: VARIANT_BCD must hold two BCD digits");
  end

  // ==========================================================
  // Helpers
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    hit = (addr == off);
  endfunction : hit

  function automatic logic [15:0] ring_word(input ext_regs_pkg::regs_state_s s);
    ring_word = 16'h0000;
    ring_word[`RING_BIT_STARTUP] = s.startup_en;
    ring_word[`RING_BIT_ADVERTISE] = s.advertise;
    ring_word[`RING_BIT_LP_ADV] = s.lp_adv;
    ring_word[`RING_BIT_FORCE] = s.force_en;
    ring_word[`RING_ROLE_HI:`RING_ROLE_LO] = s.role;
    ring_word[`RING_BIT_START] = s.start;
  endfunction : ring_word

  function automatic logic role_stable(input ext_regs_pkg::timing_role_e r);
    role_stable = (r == ext_regs_pkg::ROLE_SLAVE) || (r == ext_regs_pkg::ROLE_MASTER);
  endfunction : role_stable

  // ==========================================================
  // Fixed capability word
  logic [15:0] cap_word;
  always_comb begin
    cap_word = 16'h0000;
    cap_word[`CAP_BIT_INDUSTRIAL] = CAP_INDUSTRIAL;
    cap_word[`CAP_BIT_QUAD] = CAP_QUAD;
    cap_word[`CAP_BIT_PTP] = CAP_PTP;
    cap_word[`CAP_BIT_SEC] = CAP_SEC;
    cap_word[`CAP_BIT_DUAL_MEDIA] = CAP_DUAL_MEDIA;
    cap_word[`CAP_BIT_HI_PREC] = CAP_HI_PREC;
    cap_word[`CAP_BIT_KEY256] = CAP_KEY256;
    cap_word[`CAP_SUFFIX_HI:`CAP_SUFFIX_LO] = VARIANT_BCD;
  end

  // ==========================================================
  // Entropy source
  logic [15:0] entropy_word;
  entropy_source #(
    .SEED(ENTROPY_SEED)
  ) u_entropy (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .value_out(entropy_word)
  );

  // ==========================================================
  // State
  ext_regs_pkg::regs_state_s st_q;
  ext_regs_pkg::regs_state_s st_d;
  logic [10:0] ev_set;
  logic start_ok;
  logic done_ok;

  always_comb begin
    st_d = st_q;
    start_ok = 1'b0;
    done_ok = role_stable(st_q.role) ? 1'b0 : switchover_done_in;

    ev_set = event_in;
    ev_set[`EVT_BIT_SWITCHOVER] = event_in[`EVT_BIT_SWITCHOVER] | done_ok;

    // read data captured at the request edge
    st_d.rd_valid = acc_rd_in;
    if (acc_rd_in) begin
      if (hit(acc_addr_in, `OFF_CAP_ID)) begin
        st_d.rd_data = cap_word;
      end else if (hit(acc_addr_in, `OFF_ENTROPY)) begin
        st_d.rd_data = entropy_word;
      end else if (hit(acc_addr_in, `OFF_EVT_ENABLE)) begin
        st_d.rd_data = st_q.enable;
      end else if (hit(acc_addr_in, `OFF_EVT_PENDING)) begin
        st_d.rd_data = {5'h00, st_q.pending};
      end else if (hit(acc_addr_in, `OFF_RING)) begin
        st_d.rd_data = ring_word(st_q);
      end else begin
        st_d.rd_data = `RD_DATA_RST;
      end
    end

    // clear on read, a same-cycle event wins
    if (acc_rd_in && hit(acc_addr_in, `OFF_EVT_PENDING)) begin
      st_d.pending = ev_set;
    end else begin
      st_d.pending = st_q.pending | ev_set;
    end

    // enable bits, reserved ones writable too
    if (acc_wr_in && hit(acc_addr_in, `OFF_EVT_ENABLE)) begin
      st_d.enable = acc_wdata_in;
    end

    st_d.start = 1'b0;
    if (acc_wr_in && hit(acc_addr_in, `OFF_RING)) begin
      st_d.startup_en = acc_wdata_in[`RING_BIT_STARTUP];
      st_d.advertise = acc_wdata_in[`RING_BIT_ADVERTISE];
      st_d.force_en = acc_wdata_in[`RING_BIT_FORCE];
      // start only from a stable role with link up
      start_ok = acc_wdata_in[`RING_BIT_START] & role_stable(st_q.role) & st_q.link_seen;
      st_d.start = start_ok;
    end

    st_d.lp_adv = lp_ring_adv_in;

    // role taken from negotiation at link-up
    st_d.link_seen = link_up_in;
    if (link_up_in && !st_q.link_seen) begin
      st_d.role = neg_master_in ? ext_regs_pkg::ROLE_MASTER : ext_regs_pkg::ROLE_SLAVE;
    end else begin
      case (st_q.role)
        ext_regs_pkg::ROLE_SLAVE: begin
          if (start_ok) begin
            st_d.role = ext_regs_pkg::ROLE_SLAVE_TO_MASTER;
          end
        end
        ext_regs_pkg::ROLE_SLAVE_TO_MASTER: begin
          if (done_ok) begin
            st_d.role = ext_regs_pkg::ROLE_MASTER;
          end
        end
        ext_regs_pkg::ROLE_MASTER: begin
          if (start_ok) begin
            st_d.role = ext_regs_pkg::ROLE_MASTER_TO_SLAVE;
          end
        end
        ext_regs_pkg::ROLE_MASTER_TO_SLAVE: begin
          if (done_ok) begin
            st_d.role = ext_regs_pkg::ROLE_SLAVE;
          end
        end
        default: begin
          st_d.role = ext_regs_pkg::ROLE_SLAVE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_q.enable <= `ENABLE_RST;
      st_q.pending <= `PENDING_RST;
      st_q.startup_en <= 1'b0;
      st_q.advertise <= 1'b0;
      st_q.force_en <= 1'b0;
      st_q.lp_adv <= 1'b0;
      st_q.start <= 1'b0;
      st_q.link_seen <= 1'b0;
      st_q.role <= ext_regs_pkg::ROLE_SLAVE;
      st_q.rd_data <= `RD_DATA_RST;
      st_q.rd_valid <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  assign rd_data_out = st_q.rd_data;
  assign rd_valid_out = st_q.rd_valid;
  assign start_switchover_out = st_q.start;
  assign ring_startup_en_out = st_q.startup_en;
  assign ring_advertise_out = st_q.advertise;
  assign ring_force_out = st_q.force_en;
  assign timing_role_out = st_q.role;
  // level request from enabled pending bits
  assign irq_out = |(st_q.pending & st_q.enable[`EVT_W-1:0]);

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_read_id;
    acc_rd_in && acc_addr_in == `OFF_CAP_ID;
  endsequence

  property p_id_read;
    s_read_id |=> rd_valid_out && rd_data_out == cap_word;
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("capability read returned wrong word");

  property p_ring_read;
    acc_rd_in && acc_addr_in == `OFF_RING
      |=> rd_data_out[`RING_ROLE_HI:`RING_ROLE_LO] == $past(timing_role_out) &&
        rd_data_out[`RING_BIT_LP_ADV] == $past(st_q.lp_adv);
  endproperty
  a_ring_read: assert property (p_ring_read)
    else $error("ring read does not show role and partner bit");

  property p_pending_clear;
    acc_rd_in && acc_addr_in == `OFF_EVT_PENDING && ev_set == 11'h000
      |=> st_q.pending == 11'h000 && rd_valid_out &&
        rd_data_out == {5'h00, $past(st_q.pending)};
  endproperty
  a_pending_clear: assert property (p_pending_clear)
    else $error("pending bits not cleared by read");

  property p_set_wins;
    ev_set != 11'h000 |=> (st_q.pending & $past(ev_set)) == $past(ev_set);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost in pending register");

  property p_irq_follows;
    (st_q.pending[`EVT_BIT_WAKE_ERR] && st_q.enable[`EVT_BIT_WAKE_ERR]) ||
      (st_q.pending[`EVT_BIT_EEE_LINK_FAIL] && st_q.enable[`EVT_BIT_EEE_LINK_FAIL])
      |-> irq_out;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("enabled pending event without request");

  property p_irq_masked;
    st_q.enable == 16'h0000 |-> !irq_out;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("request raised with all events disabled");

  property p_enable_write;
    acc_wr_in && acc_addr_in == `OFF_EVT_ENABLE |=> st_q.enable == $past(acc_wdata_in);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable register write not stored");

  sequence s_start_from_slave;
    acc_wr_in && acc_addr_in == `OFF_RING && acc_wdata_in[`RING_BIT_START] &&
      st_q.role == ext_regs_pkg::ROLE_SLAVE && st_q.link_seen && link_up_in;
  endsequence

  sequence s_pulse_and_move;
    start_switchover_out && timing_role_out == 2'b10 ##1 !start_switchover_out;
  endsequence

  property p_start_pulse;
    s_start_from_slave |=> s_pulse_and_move;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("switchover start did not pulse once");

  property p_start_refused;
    acc_wr_in && acc_addr_in == `OFF_RING && acc_wdata_in[`RING_BIT_START] &&
      !(role_stable(st_q.role) && st_q.link_seen)
      |=> !start_switchover_out;
  endproperty
  a_start_refused: assert property (p_start_refused)
    else $error("switchover start accepted while refused");

  property p_done_completes;
    switchover_done_in && st_q.role == ext_regs_pkg::ROLE_SLAVE_TO_MASTER &&
      link_up_in && st_q.link_seen
      |=> timing_role_out == 2'b11 && st_q.pending[`EVT_BIT_SWITCHOVER];
  endproperty
  a_done_completes: assert property (p_done_completes)
    else $error("switchover completion not recorded");

  property p_done_ignored;
    switchover_done_in && !event_in[`EVT_BIT_SWITCHOVER] &&
      !st_q.pending[`EVT_BIT_SWITCHOVER] && st_q.role == ext_regs_pkg::ROLE_MASTER &&
      !acc_wr_in && link_up_in && st_q.link_seen
      |=> !st_q.pending[`EVT_BIT_SWITCHOVER] && timing_role_out == 2'b11;
  endproperty
  a_done_ignored: assert property (p_done_ignored)
    else $error("completion acted on in a stable role");

  property p_linkup_role;
    link_up_in && !st_q.link_seen |=> timing_role_out == ($past(neg_master_in) ? 2'b11 : 2'b00);
  endproperty
  a_linkup_role: assert property (p_linkup_role)
    else $error("role not taken from negotiation at link-up");

  property p_lp_adv;
    ##1 st_q.lp_adv == $past(lp_ring_adv_in);
  endproperty
  a_lp_adv: assert property (p_lp_adv)
    else $error("partner advertisement bit stale");

endmodule : ext_id_irq_ring_regs

// ===== tb/ext_id_irq_ring_regs_tb.sv
// Self-checking bench for the extended capability, event and ring register group
`timescale 1ns/1ps
`include "ext_regs_defs.svh"

module ext_id_irq_ring_regs_tb;
  // ==========================================================
  // Stimulus and observed signals
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [4:0] acc_addr_in = 5'h00;
  logic acc_wr_in = 1'b0;
  logic [15:0] acc_wdata_in = 16'h0000;
  logic acc_rd_in = 1'b0;
  logic [10:0] event_in = 11'h000;
  logic link_up_in = 1'b0;
  logic neg_master_in = 1'b0;
  logic lp_ring_adv_in = 1'b0;
  logic switchover_done_in = 1'b0;
  logic [15:0] rd_data_out;
  logic rd_valid_out;
  logic start_switchover_out;
  logic ring_startup_en_out;
  logic ring_advertise_out;
  logic ring_force_out;
  logic [1:0] timing_role_out;
  logic irq_out;
  int errors = 0;
  int checked = 0;

  always #4 clk_in = ~clk_in;

  ext_id_irq_ring_regs ext_id_irq_ring_regs_inst (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .acc_addr_in(acc_addr_in),
    .acc_wr_in(acc_wr_in),
    .acc_wdata_in(acc_wdata_in),
    .acc_rd_in(acc_rd_in),
    .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out),
    .event_in(event_in),
    .link_up_in(link_up_in),
    .neg_master_in(neg_master_in),
    .lp_ring_adv_in(lp_ring_adv_in),
    .switchover_done_in(switchover_done_in),
    .start_switchover_out(start_switchover_out),
    .ring_startup_en_out(ring_startup_en_out),
    .ring_advertise_out(ring_advertise_out),
    .ring_force_out(ring_force_out),
    .timing_role_out(timing_role_out),
    .irq_out(irq_out)
  );

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Inputs move 1 ns after the edge so no race with the design's sampling
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask : tick

  task automatic write_reg(input logic [4:0] addr, input logic [15:0] data);
    tick();
    acc_addr_in = addr;
    acc_wdata_in = data;
    acc_wr_in = 1'b1;
    tick();
    acc_wr_in = 1'b0;
  endtask : write_reg

  task automatic read_reg(input logic [4:0] addr, output logic [15:0] data);
    tick();
    acc_addr_in = addr;
    acc_rd_in = 1'b1;
    tick();
    acc_rd_in = 1'b0;
    check("read valid", 16'h0001, {15'h0000, rd_valid_out});
    data = rd_data_out;
  endtask : read_reg

  task automatic expect_reg(input string what, input logic [4:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    read_reg(addr, d);
    check(what, exp, d);
  endtask : expect_reg

  task automatic pulse_done();
    tick();
    switchover_done_in = 1'b1;
    tick();
    switchover_done_in = 1'b0;
  endtask : pulse_done

  task automatic pulse_event(input int idx);
    tick();
    event_in = 11'h001 << idx;
    tick();
    event_in = 11'h000;
  endtask : pulse_event

  task automatic test_done();
    $display("counts: checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // ==========================================================
  // Scenarios
  task automatic t_reset_and_id();
    check("role after reset", 16'h0000, {14'h0000, timing_role_out});
    // Default parameters: quad, timing, security, dual media, 256-bit keys, suffix 01
    expect_reg("capability word", `OFF_CAP_ID, 16'h7501);
    write_reg(`OFF_CAP_ID, 16'h0000);
    expect_reg("capability after write", `OFF_CAP_ID, 16'h7501);
    expect_reg("enable reset", `OFF_EVT_ENABLE, 16'h0000);
    expect_reg("pending reset", `OFF_EVT_PENDING, 16'h0000);
    expect_reg("ring reset", `OFF_RING, 16'h0000);
    expect_reg("unmapped read", 5'h00, 16'h0000);
    $display("test reset_and_id done");
  endtask : t_reset_and_id

  task automatic t_entropy();
    logic [15:0] a;
    logic [15:0] b;
    read_reg(`OFF_ENTROPY, a);
    read_reg(`OFF_ENTROPY, b);
    check("entropy fresh", 16'h0001, {15'h0000, a !== b});
    write_reg(`OFF_ENTROPY, a);
    read_reg(`OFF_ENTROPY, b);
    check("entropy after write", 16'h0001, {15'h0000, a !== b});
    $display("test entropy done");
  endtask : t_entropy

  task automatic t_enable_and_events();
    write_reg(`OFF_EVT_ENABLE, 16'hFFFF);
    expect_reg("enable all ones", `OFF_EVT_ENABLE, 16'hFFFF);
    // Walk every event source through set, interrupt, read and clear
    for (int i = 0; i < 11; i++) begin
      write_reg(`OFF_EVT_ENABLE, 16'h0001 << i);
      pulse_event(i);
      check("irq raised", 16'h0001, {15'h0000, irq_out});
      expect_reg("pending bit", `OFF_EVT_PENDING, 16'h0001 << i);
      check("irq withdrawn", 16'h0000, {15'h0000, irq_out});
      expect_reg("pending cleared", `OFF_EVT_PENDING, 16'h0000);
    end
    // A masked event still pends but must not interrupt
    write_reg(`OFF_EVT_ENABLE, 16'h0000);
    pulse_event(3);
    check("irq masked", 16'h0000, {15'h0000, irq_out});
    write_reg(`OFF_EVT_PENDING, 16'hFFFF);
    expect_reg("pending masked", `OFF_EVT_PENDING, 16'h0008);
    $display("test enable_and_events done");
  endtask : t_enable_and_events

  task automatic t_ring_controls();
    lp_ring_adv_in = 1'b1;
    // Link is down so the start bit in this write must be refused
    write_reg(`OFF_RING, 16'hFFFF);
    check("start refused", 16'h0000, {15'h0000, start_switchover_out});
    check("ring outputs", 16'h0007,
          {13'h0000, ring_startup_en_out, ring_advertise_out, ring_force_out});
    expect_reg("ring all written", `OFF_RING, 16'hF000);
    write_reg(`OFF_RING, 16'h0000);
    expect_reg("ring partner only", `OFF_RING, 16'h2000);
    lp_ring_adv_in = 1'b0;
    tick();
    expect_reg("ring partner gone", `OFF_RING, 16'h0000);
    $display("test ring_controls done");
  endtask : t_ring_controls

  task automatic t_switchover();
    write_reg(`OFF_EVT_ENABLE, 16'h0010);
    neg_master_in = 1'b0;
    link_up_in = 1'b1;
    tick();
    tick();
    check("role at link up", 16'(ext_regs_pkg::ROLE_SLAVE), {14'h0000, timing_role_out});
    write_reg(`OFF_RING, 16'h0001);
    check("start pulse", 16'h0001, {15'h0000, start_switchover_out});
    check("role rising", 16'(ext_regs_pkg::ROLE_SLAVE_TO_MASTER),
          {14'h0000, timing_role_out});
    tick();
    check("start self clear", 16'h0000, {15'h0000, start_switchover_out});
    write_reg(`OFF_RING, 16'h0001);
    check("start in progress", 16'h0000, {15'h0000, start_switchover_out});
    pulse_done();
    check("role master", 16'(ext_regs_pkg::ROLE_MASTER), {14'h0000, timing_role_out});
    check("irq on completion", 16'h0001, {15'h0000, irq_out});
    expect_reg("completion pending", `OFF_EVT_PENDING, 16'h0010);
    // A completion pulse in a stable role changes nothing
    pulse_done();
    check("role kept", 16'(ext_regs_pkg::ROLE_MASTER), {14'h0000, timing_role_out});
    expect_reg("no stray completion", `OFF_EVT_PENDING, 16'h0000);
    write_reg(`OFF_RING, 16'h0001);
    check("role falling", 16'(ext_regs_pkg::ROLE_MASTER_TO_SLAVE),
          {14'h0000, timing_role_out});
    pulse_done();
    check("role slave", 16'(ext_regs_pkg::ROLE_SLAVE), {14'h0000, timing_role_out});
    expect_reg("second completion", `OFF_EVT_PENDING, 16'h0010);
    // A fresh link-up reloads the negotiated role
    link_up_in = 1'b0;
    neg_master_in = 1'b1;
    tick();
    link_up_in = 1'b1;
    tick();
    tick();
    check("role reloaded", 16'(ext_regs_pkg::ROLE_MASTER), {14'h0000, timing_role_out});
    link_up_in = 1'b0;
    $display("test switchover done");
  endtask : t_switchover

  // ==========================================================
  // Main sequence and hang guard
  initial begin
    repeat (20) @(posedge clk_in);
    #1;
    resetn_in = 1'b1;
    t_reset_and_id();
    t_entropy();
    t_enable_and_events();
    t_ring_controls();
    t_switchover();
    tick();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    $display("mismatch run length expected finish seen hang");
    test_done();
  end
endmodule : ext_id_irq_ring_regs_tb
